/* File: hw/asc_pkg.sv */
// Constants, field layouts and types shared by the serial configuration logic
package asc_pkg;

  // Serial framing
  localparam logic [2:0]  BYTE_BIT_LAST   = 3'h7;   // Eighth bit of an input byte
  localparam logic [3:0]  WORD_BIT_LAST   = 4'hf;   // Sixteenth bit of an output word
  localparam logic [3:0]  LEAD_ZEROS      = 4'h0;   // Leading nibble of every output word

  // Byte selector bits
  localparam int          SEL_CONV_BIT    = 7;
  localparam int          SEL_SETUP_BIT   = 6;
  localparam int          SEL_AVG_BIT     = 5;

  // Setup byte fields
  localparam int          CLK_HI_BIT      = 5;
  localparam int          CLK_LO_BIT      = 4;
  localparam int          REF_HI_BIT      = 3;
  localparam int          REF_LO_BIT      = 2;
  localparam int          ROUTE_HI_BIT    = 1;
  localparam int          ROUTE_LO_BIT    = 0;

  // Averaging byte fields
  localparam int          AVG_ON_BIT      = 4;
  localparam int          AVG_CNT_HI_BIT  = 3;
  localparam int          AVG_CNT_LO_BIT  = 2;
  localparam int          REP_HI_BIT      = 1;
  localparam int          REP_LO_BIT      = 0;

  // Power-up values
  localparam logic [7:0]  SETUP_RESET     = 8'h20;  // Clock mode 10
  localparam logic [7:0]  PAIR_RESET      = 8'h00;
  localparam logic [7:0]  AVG_RESET       = 8'h00;
  localparam logic [6:0]  CONV_RESET      = 7'h00;

  // Clock modes
  localparam logic [1:0]  CLK_INT_CONVERT_START_PIN   = 2'h0;
  localparam logic [1:0]  CLK_EXT_ACQ     = 2'h1;
  localparam logic [1:0]  CLK_INT_SERIAL  = 2'h2;
  localparam logic [1:0]  CLK_SCLK        = 2'h3;
  localparam int          SCLK_CONV_MAX_KHZ = 4800; // Serial clock limit in clock mode 11

  // Reference modes
  localparam logic [1:0]  REF_INT_AUTO    = 2'h0;
  localparam logic [1:0]  REF_EXT_SE      = 2'h1;
  localparam logic [1:0]  REF_INT_ON      = 2'h2;
  localparam logic [1:0]  REF_EXT_DIFF    = 2'h3;

  // Pair routing codes
  localparam logic [1:0]  ROUTE_UNI       = 2'h2;
  localparam logic [1:0]  ROUTE_BIP       = 2'h3;

  // Conversions per result and repeat result counts
  localparam logic [5:0]  AVG_NONE        = 6'h01;
  localparam logic [5:0]  AVG_N4          = 6'h04;
  localparam logic [5:0]  AVG_N8          = 6'h08;
  localparam logic [5:0]  AVG_N16         = 6'h10;
  localparam logic [5:0]  AVG_N32         = 6'h20;
  localparam logic [4:0]  REP_N4          = 5'h04;
  localparam logic [4:0]  REP_N8          = 5'h08;
  localparam logic [4:0]  REP_N12         = 5'h0c;
  localparam logic [4:0]  REP_N16         = 5'h10;

  // Kelvin to Celsius offset in eighths of a degree
  localparam logic [11:0] TEMP_OFFSET     = 12'h888;

  // Byte decoder state
  typedef enum logic [1:0] {
    asc_st_cmd,
    asc_st_uni,
    asc_st_bip
  } asc_state_type;

endpackage : asc_pkg

/* File: hw/asc_sync2.sv */
// Two flip-flop synchroniser for a level crossing into a clock domain
`timescale 1ns/100ps
module asc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : asc_sync2

/* File: hw/asc_result_fmt.sv */
// Result word formatting: polarity coding, temperature arithmetic, framing
`timescale 1ns/100ps
module asc_result_fmt (
  input  wire logic [9:0]  code,
  input  wire logic [1:0]  subbits,
  input  wire logic [2:0]  pair,
  input  wire logic        is_diff,
  input  wire logic        is_temp,
  input  wire logic [11:0] temp_first,
  input  wire logic [11:0] temp_second,
  input  wire logic [7:0]  uni_cfg,
  input  wire logic [7:0]  bip_cfg,
  output logic      [15:0] word
);

  logic        bipolar;
  logic [9:0]  coded;
  logic [11:0] temp_c;

  // Pair 0 sits at bit 7; unipolar wins when both are set
  assign bipolar = is_diff & bip_cfg[3'h7 - pair] & ~uni_cfg[3'h7 - pair];

  // Offset binary becomes two's complement by flipping the top bit
  assign coded = bipolar ? {~code[9], code[8:0]} : code;

  // First diode reading minus second, then shifted to Celsius
  assign temp_c = temp_first - temp_second - asc_pkg::TEMP_OFFSET;

  // Four leading zeros, then ten bits and two sub-bits, or a twelve-bit temperature
  assign word = is_temp ? {asc_pkg::LEAD_ZEROS, temp_c}
                        : {asc_pkg::LEAD_ZEROS, coded, subbits};

endmodule : asc_result_fmt

/* File: hw/asc_serial_config.sv */
// Serial configuration port: byte capture, register decode, mode outputs, result shifting
//
// Overview of operation
// - Byte with bit 7 low and bit 6 high writes the setup register.
// - Clock modes 00/01: internal clock, start pin dedicated; 01 times acquisition by pin.
// - Modes 10/11 free the start pin; 11 clocks conversions by serial clock, 4.8MHz max.
// - Reference mode 00: internal, off after scan, wake-up delay, negative pin stays analog.
// - Reference mode 10: internal reference stays powered once woken by a request, no wake-up delay.
// - Modes 01/11 external reference, internal off; only 11 makes pin negative reference.
// - Routing 00/01: no data byte follows, pair registers unchanged.
// - Routing 10 stores next byte as unipolar pairs, 11 as bipolar pairs.
// - Power-up: all registers zero except setup, which starts in clock mode 10.
// - Power-up: all blocks and reference shut down until a conversion request.
// - Temperature is first diode reading minus second, offset to Celsius, eighth degrees.
// - Voltage result goes out MSB first: four zeros, ten bits, two sub-bits.
// - Temperature result goes out as four zeros and twelve bits.
// - Input bits are captured on rising serial clock; host holds them stable.
// - Output bit changes only on falling serial clock edges.
// - Modes 00/01 start from the start pin; 10/11 from a conversion byte.
// - Unipolar results are straight binary, bipolar pairs two's complement.
// - Unipolar register bit 7 enables pair 0/1 down to bit 0 for pair 14/15.
// - Bipolar register bit 7 enables pair 0/1 down to bit 0 for pair 14/15.
// - Bits 7:6 zero, bit 5 set writes averaging: enable, average count, repeat count.
// - Averaging off, or clock mode 11, gives one conversion; on gives 4, 8, 16 or 32.
// - Repeat scan codes give 4, 8, 12 or 16 results.
// - Pair enabled in both registers is treated as unipolar.
// - Byte with bit 7 set is a conversion register write.
// - After a setup byte with routing 00/01, the next byte is a new command.
`timescale 1ns/100ps
module asc_serial_config (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic        convert_start_pin,
  input  wire logic        scan_done,
  input  wire logic        result_valid,
  input  wire logic [9:0]  result_code,
  input  wire logic [1:0]  result_subbits,
  input  wire logic [2:0]  result_pair,
  input  wire logic        result_is_diff,
  input  wire logic        result_is_temp,
  input  wire logic [11:0] temp_first,
  input  wire logic [11:0] temp_second,
  output logic             dout,
  output logic [7:0]       converter_setup_ff,
  output logic [7:0]       unipolar_pair_config_ff,
  output logic [7:0]       bipolar_pair_config_ff,
  output logic [7:0]       averaging_config_ff,
  output logic             start_pin_dedicated_ff,
  output logic             acq_by_pin_ff,
  output logic             sclk_conv_clock_ff,
  output logic             ref_internal_ff,
  output logic             ref_wake_delay_ff,
  output logic             refneg_is_ref_ff,
  output logic             ref_powered_ff,
  output logic             blocks_awake_ff,
  output logic [5:0]       conversions_per_result_ff,
  output logic [4:0]       repeat_results_ff,
  output logic             conv_request_ff,
  output logic [6:0]       conv_command_ff
);

  // ---------------------------------------------------------------------------
  // Link domain (serial clock)
  // ---------------------------------------------------------------------------
  logic [2:0]  in_cnt_ff;
  logic [6:0]  in_shift_ff;
  logic [7:0]  in_byte_ff;
  logic        in_tog_ff;
  logic [15:0] out_shift_ff;
  logic [3:0]  out_cnt_ff;
  logic        out_taken_ff;
  logic        word_tog_link;
  logic [15:0] word_ff;                                                   // Core-domain word, read at slot start
  logic        word_tog_ff;                                               // Core-domain toggle, synced below

  // Bit counter is cleared by the frame itself, so a stopped clock cannot leave it stale
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      in_cnt_ff <= 3'h0;
    end else begin
      in_cnt_ff <= in_cnt_ff + 3'h1;
    end
  end

  // Shift DIN in on the rising edge, MSB first
  always_ff @(posedge sclk) begin
    if (!cs_n) begin
      in_shift_ff <= {in_shift_ff[5:0], din};
    end
  end

  // Complete byte is held for a full byte time while the core picks it up
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      in_byte_ff <= asc_pkg::PAIR_RESET;
      in_tog_ff  <= 1'b0;
    end else if (!cs_n && in_cnt_ff == asc_pkg::BYTE_BIT_LAST) begin
      in_byte_ff <= {in_shift_ff, din};
      in_tog_ff  <= ~in_tog_ff;
    end
  end

  // Word toggle from the core, seen in the link domain
  asc_sync2 #(.W(1)) u_word_sync (
    .clk (sclk),
    .rst_n (rst_n),
    .d   (word_tog_ff),
    .q   (word_tog_link)
  );

  // Output shifts on falling edges; a pending word is loaded at a word boundary, else zeros
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      out_shift_ff <= 16'h0000;
      out_cnt_ff   <= 4'h0;
      out_taken_ff <= 1'b0;
    end else if (!cs_n) begin
      if (out_cnt_ff == asc_pkg::WORD_BIT_LAST) begin
        out_cnt_ff <= 4'h0;
        if (word_tog_link != out_taken_ff) begin
          out_shift_ff <= word_ff;
          out_taken_ff <= word_tog_link;
        end else begin
          out_shift_ff <= 16'h0000;                                       // Nothing pending: zeros
        end
      end else begin
        out_cnt_ff   <= out_cnt_ff + 4'h1;
        out_shift_ff <= {out_shift_ff[14:0], 1'b0};
      end
    end
  end

  // DOUT is the shift register MSB, so it only moves on a falling edge
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 1'b0;
    end else if (!cs_n) begin
      if (out_cnt_ff == asc_pkg::WORD_BIT_LAST) begin
        dout <= (word_tog_link != out_taken_ff) ? word_ff[15] : 1'b0;
      end else begin
        dout <= out_shift_ff[14];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Core domain
  // ---------------------------------------------------------------------------
  logic                  in_tog_core;
  logic                  in_seen_ff;
  logic                  cs_n_core;
  logic                  start_pin_core;
  logic                  start_pin_prev_ff;
  logic                  byte_strobe;
  logic [7:0]            rx_byte;
  logic [15:0]           fmt_word;
  logic [1:0]            clk_mode;
  logic [1:0]            ref_mode;
  logic                  pin_start;
  logic                  byte_start;
  asc_pkg::asc_state_type state_ff;
  asc_pkg::asc_state_type nxt_state;

  asc_sync2 #(.W(3)) u_core_sync (
    .clk (core_clk),
    .rst_n (rst_n),
    .d   ({in_tog_ff, cs_n, convert_start_pin}),
    .q   ({in_tog_core, cs_n_core, start_pin_core})
  );

  assign clk_mode = converter_setup_ff[asc_pkg::CLK_HI_BIT:asc_pkg::CLK_LO_BIT];
  assign ref_mode = converter_setup_ff[asc_pkg::REF_HI_BIT:asc_pkg::REF_LO_BIT];

  // Byte held stable by the link for eight serial clocks, long past the sync delay
  assign byte_strobe = clk_en & (in_tog_core != in_seen_ff);
  assign rx_byte     = in_byte_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      in_seen_ff        <= 1'b0;
      start_pin_prev_ff <= 1'b1;
    end else if (clk_en) begin
      in_seen_ff        <= in_tog_core;
      start_pin_prev_ff <= start_pin_core;
    end
  end

  // Decoder state: a routing code of 10 or 11 claims the next byte
  // A byte that completed just before chip select rose is still decoded, since both cross together
  always_comb begin
    nxt_state = state_ff;
    if (byte_strobe) begin
      case (state_ff)
        asc_pkg::asc_st_cmd: begin
          if (!rx_byte[asc_pkg::SEL_CONV_BIT] && rx_byte[asc_pkg::SEL_SETUP_BIT]
              && rx_byte[asc_pkg::ROUTE_HI_BIT:asc_pkg::ROUTE_LO_BIT] == asc_pkg::ROUTE_UNI) begin
            nxt_state = asc_pkg::asc_st_uni;
          end else if (!rx_byte[asc_pkg::SEL_CONV_BIT] && rx_byte[asc_pkg::SEL_SETUP_BIT]
              && rx_byte[asc_pkg::ROUTE_HI_BIT:asc_pkg::ROUTE_LO_BIT] == asc_pkg::ROUTE_BIP) begin
            nxt_state = asc_pkg::asc_st_bip;
          end else begin
            nxt_state = asc_pkg::asc_st_cmd;
          end
        end
        default: begin
          nxt_state = asc_pkg::asc_st_cmd;
        end
      endcase
    end else if (cs_n_core) begin
      nxt_state = asc_pkg::asc_st_cmd;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= asc_pkg::asc_st_cmd;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // Setup register, written only by a command byte with selector 01
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      converter_setup_ff <= asc_pkg::SETUP_RESET;
    end else if (byte_strobe && state_ff == asc_pkg::asc_st_cmd
                 && !rx_byte[asc_pkg::SEL_CONV_BIT] && rx_byte[asc_pkg::SEL_SETUP_BIT]) begin
      converter_setup_ff <= rx_byte;
    end
  end

  // Pair registers take only a follow-on byte; a command byte never touches them
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      unipolar_pair_config_ff <= asc_pkg::PAIR_RESET;
      bipolar_pair_config_ff  <= asc_pkg::PAIR_RESET;
    end else if (byte_strobe) begin
      if (state_ff == asc_pkg::asc_st_uni) begin
        unipolar_pair_config_ff <= rx_byte;
      end else if (state_ff == asc_pkg::asc_st_bip) begin
        bipolar_pair_config_ff <= rx_byte;
      end
    end
  end

  // Averaging register: selector 001
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      averaging_config_ff <= asc_pkg::AVG_RESET;
    end else if (byte_strobe && state_ff == asc_pkg::asc_st_cmd && !rx_byte[asc_pkg::SEL_CONV_BIT]
                 && !rx_byte[asc_pkg::SEL_SETUP_BIT] && rx_byte[asc_pkg::SEL_AVG_BIT]) begin
      averaging_config_ff <= rx_byte;
    end
  end

  // Conversion byte: top bit set wins over every other selector
  assign byte_start = byte_strobe && state_ff == asc_pkg::asc_st_cmd && rx_byte[asc_pkg::SEL_CONV_BIT];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv_command_ff <= asc_pkg::CONV_RESET;
    end else if (byte_start) begin
      conv_command_ff <= rx_byte[6:0];
    end
  end

  // Start pin rising edge starts work only when the pin is dedicated to it
  assign pin_start = clk_en && start_pin_core && !start_pin_prev_ff
                     && (clk_mode == asc_pkg::CLK_INT_CONVERT_START_PIN || clk_mode == asc_pkg::CLK_EXT_ACQ);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv_request_ff <= 1'b0;
    end else if (clk_en) begin
      if (clk_mode == asc_pkg::CLK_INT_CONVERT_START_PIN || clk_mode == asc_pkg::CLK_EXT_ACQ) begin
        conv_request_ff <= pin_start;
      end else begin
        conv_request_ff <= byte_start;
      end
    end
  end

  // Clock-mode decode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      start_pin_dedicated_ff <= 1'b0;
      acq_by_pin_ff          <= 1'b0;
      sclk_conv_clock_ff     <= 1'b0;
    end else if (clk_en) begin
      start_pin_dedicated_ff <= (clk_mode == asc_pkg::CLK_INT_CONVERT_START_PIN)
                                || (clk_mode == asc_pkg::CLK_EXT_ACQ);
      acq_by_pin_ff          <= (clk_mode == asc_pkg::CLK_EXT_ACQ);
      sclk_conv_clock_ff     <= (clk_mode == asc_pkg::CLK_SCLK);
    end
  end

  // Reference-mode decode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_internal_ff   <= 1'b0;
      ref_wake_delay_ff <= 1'b0;
      refneg_is_ref_ff  <= 1'b0;
    end else if (clk_en) begin
      ref_internal_ff   <= (ref_mode == asc_pkg::REF_INT_AUTO)
                           || (ref_mode == asc_pkg::REF_INT_ON);
      ref_wake_delay_ff <= (ref_mode == asc_pkg::REF_INT_AUTO);
      refneg_is_ref_ff  <= (ref_mode == asc_pkg::REF_EXT_DIFF);
    end
  end

  // Power state: asleep from reset until the first request; a finished scan sleeps again
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      blocks_awake_ff <= 1'b0;
    end else if (clk_en) begin
      if (conv_request_ff) begin
        blocks_awake_ff <= 1'b1;                                          // Request wins over done
      end else if (scan_done) begin
        blocks_awake_ff <= 1'b0;
      end
    end
  end

  // Reference follows the scan in mode 00, stays up once woken in mode 10, else off
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_powered_ff <= 1'b0;
    end else if (clk_en) begin
      if (ref_mode == asc_pkg::REF_INT_ON) begin
        ref_powered_ff <= ref_powered_ff | conv_request_ff;
      end else if (ref_mode == asc_pkg::REF_INT_AUTO) begin
        ref_powered_ff <= conv_request_ff | (blocks_awake_ff & ~scan_done);
      end else begin
        ref_powered_ff <= 1'b0;
      end
    end
  end

  // Averaging decode; the serial-clock mode cannot average
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conversions_per_result_ff <= asc_pkg::AVG_NONE;
    end else if (clk_en) begin
      if (!averaging_config_ff[asc_pkg::AVG_ON_BIT] || clk_mode == asc_pkg::CLK_SCLK) begin
        conversions_per_result_ff <= asc_pkg::AVG_NONE;
      end else begin
        case (averaging_config_ff[asc_pkg::AVG_CNT_HI_BIT:asc_pkg::AVG_CNT_LO_BIT])
          2'h0:    conversions_per_result_ff <= asc_pkg::AVG_N4;
          2'h1:    conversions_per_result_ff <= asc_pkg::AVG_N8;
          2'h2:    conversions_per_result_ff <= asc_pkg::AVG_N16;
          default: conversions_per_result_ff <= asc_pkg::AVG_N32;
        endcase
      end
    end
  end

  // Repeat count, consumed only by the single-channel repeat scan
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      repeat_results_ff <= asc_pkg::REP_N4;
    end else if (clk_en) begin
      case (averaging_config_ff[asc_pkg::REP_HI_BIT:asc_pkg::REP_LO_BIT])
        2'h0:    repeat_results_ff <= asc_pkg::REP_N4;
        2'h1:    repeat_results_ff <= asc_pkg::REP_N8;
        2'h2:    repeat_results_ff <= asc_pkg::REP_N12;
        default: repeat_results_ff <= asc_pkg::REP_N16;
      endcase
    end
  end

  asc_result_fmt u_fmt (
    .code        (result_code),
    .subbits     (result_subbits),
    .pair        (result_pair),
    .is_diff     (result_is_diff),
    .is_temp     (result_is_temp),
    .temp_first  (temp_first),
    .temp_second (temp_second),
    .uni_cfg     (unipolar_pair_config_ff),
    .bip_cfg     (bipolar_pair_config_ff),
    .word        (fmt_word)
  );

  // Result word handed to the link by a toggle; word stays put until the next result
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      word_ff     <= 16'h0000;
      word_tog_ff <= 1'b0;
    end else if (clk_en && result_valid) begin
      word_ff     <= fmt_word;
      word_tog_ff <= ~word_tog_ff;
    end
  end

endmodule : asc_serial_config

/* File: verification/asc_host_model.sv */
// Serial host model: frames bytes on the link and collects result words
`timescale 1ns/100ps
module asc_host_model (
  input  wire logic rst_n,
  input  wire logic dout,
  output logic      sclk = 1'b0,
  output logic      cs_n = 1'b1,
  output logic      din  = 1'b0
);
  logic [15:0] rx;
  logic [15:0] got;
  int          fc;
  // Falls since reset, tracking the free-running output slot
  always @(negedge sclk or negedge rst_n) fc <= rst_n ? fc + 1 : 0;
  // A slot's last bit is taken after its 16th fall
  always @(posedge sclk) begin
    rx = {rx[14:0], dout};
    if (fc % 16 == 15 && rx != 16'h0000) got = rx;
  end
  // Clock idles low between frames; din changes only while the clock is low
  task automatic frame(input logic [39:0] w, input int nb);
    cs_n = 1'b0;
    #10;
    for (int i = nb * 8 - 1; i >= 0; i--) begin
      din = w[i];
      #7.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
    #10 cs_n = 1'b1;
    din = ~din; // Released line shows the inverse
    #30;
  endtask : frame
endmodule : asc_host_model

/* File: verification/asc_serial_config_sva.sv */
// Checker for setup decode, power-up value and request pulse
`timescale 1ns/100ps
module asc_serial_config_sva (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] converter_setup_ff,
  input wire logic       start_pin_dedicated_ff,
  input wire logic       acq_by_pin_ff,
  input wire logic       sclk_conv_clock_ff,
  input wire logic       ref_internal_ff,
  input wire logic       ref_wake_delay_ff,
  input wire logic       refneg_is_ref_ff,
  input wire logic       conv_request_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_start_pin_use: assert property ($past(rst_n) |-> start_pin_dedicated_ff == !$past(converter_setup_ff[5]))
    else $error("start pin use wrong");
  a_acq_by_pin: assert property ($past(rst_n) |-> acq_by_pin_ff == ($past(converter_setup_ff[5:4]) == 2'h1))
    else $error("acquisition mode wrong");
  a_sclk_conv_clk: assert property ($past(rst_n) |-> sclk_conv_clock_ff == (&$past(converter_setup_ff[5:4])))
    else $error("conversion clock wrong");
  a_ref_internal: assert property ($past(rst_n) |-> ref_internal_ff == !$past(converter_setup_ff[2]))
    else $error("reference source wrong");
  a_ref_wake_delay: assert property ($past(rst_n) |-> ref_wake_delay_ff == ($past(converter_setup_ff[3:2]) == 2'h0))
    else $error("wake delay wrong");
  a_refneg_pin: assert property ($past(rst_n) |-> refneg_is_ref_ff == (&$past(converter_setup_ff[3:2])))
    else $error("negative pin use wrong");
  a_setup_powerup: assert property ($rose(rst_n) |-> converter_setup_ff == 8'h20)
    else $error("setup power-up wrong");
  a_request_pulse: assert property (conv_request_ff |=> !conv_request_ff)
    else $error("request not one cycle");
  c_request: cover property (conv_request_ff);
  c_sclk_mode: cover property (sclk_conv_clock_ff);
  c_refneg: cover property (refneg_is_ref_ff);
endmodule : asc_serial_config_sva
bind asc_serial_config asc_serial_config_sva chk_i (.*);

/* File: verification/adc_serial_config_registers_tb_top.sv */
// Bench: host frames, decode and register checks, result words
`timescale 1ns/100ps
module adc_serial_config_registers_tb_top;
  logic        core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, convert_start_pin = 1'b0, scan_done = 1'b0;
  logic        result_valid = 1'b0, result_is_diff = 1'b0, result_is_temp = 1'b0, sclk, cs_n, din, dout;
  logic [9:0]  result_code = 10'h000;
  logic [1:0]  result_subbits = 2'h0;
  logic [2:0]  result_pair = 3'h0;
  logic [11:0] temp_first = 12'h000, temp_second = 12'h000;
  logic [7:0]  converter_setup_ff, unipolar_pair_config_ff, bipolar_pair_config_ff, averaging_config_ff, b, u, p;
  logic        start_pin_dedicated_ff, acq_by_pin_ff, sclk_conv_clock_ff, ref_internal_ff, ref_wake_delay_ff;
  logic        refneg_is_ref_ff, ref_powered_ff, blocks_awake_ff, conv_request_ff, f;
  logic [5:0]  conversions_per_result_ff;
  logic [4:0]  repeat_results_ff;
  logic [6:0]  conv_command_ff;
  int          errors = 0, tests_run = 0;
  asc_serial_config uut (.*);
  asc_host_model host (.*);
  // Core clock at 40 MHz
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // Register writes settle within a few core cycles; sample off the edge
  task automatic wr(input logic [39:0] w, input int nb);
    host.frame(w, nb);
    repeat (8) @(posedge core_clk);
    #1;
  endtask : wr
  // Watchdog against a hung run
  initial begin
    #2000000;
    errors++;
    test_done();
  end
  initial begin
    void'($urandom(32'ha9c32f76));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk("setup", converter_setup_ff, 8'h20);
    chk("regs", {unipolar_pair_config_ff, averaging_config_ff | bipolar_pair_config_ff}, 16'h0000);
    chk("power", {blocks_awake_ff, ref_powered_ff}, 2'h0);
    $display("reset test done");
    for (int m = 0; m < 16; m++) begin
      b = {2'b01, m[3:0] ^ 4'h8, 1'b0, 1'($urandom)};
      wr(b, 1);
      chk("setup", converter_setup_ff, b);
      chk("decode", {start_pin_dedicated_ff, acq_by_pin_ff, sclk_conv_clock_ff, ref_internal_ff, ref_wake_delay_ff,
        refneg_is_ref_ff}, {!b[5], b[5:4] == 2'h1, &b[5:4], !b[2], b[3:2] == 2'h0, &b[3:2]});
    end
    chk("pairs", {unipolar_pair_config_ff, bipolar_pair_config_ff}, 16'h0000);
    u = 8'($urandom);
    p = 8'($urandom);
    wr({8'h62, u}, 2);
    wr({8'h63, p}, 2);
    chk("pairs", {unipolar_pair_config_ff, bipolar_pair_config_ff}, {u, p});
    $display("setup test done");
    for (int a = 0; a < 32; a++) begin
      b = {3'b001, a[4:0]};
      wr(b, 1);
      chk("avg", averaging_config_ff, b);
      chk("navg", conversions_per_result_ff, b[4] ? 6'h04 << b[3:2] : 6'h01);
      chk("nrep", repeat_results_ff, 5'h04 * (b[1:0] + 1));
    end
    b = 8'h80 | 8'($urandom);
    wr(b, 1);
    chk("conv", conv_command_ff, b[6:0]);
    $display("averaging test done");
    for (int r = 0; r < 8; r++) begin
      @(posedge core_clk);
      {result_code, result_subbits, result_pair, result_is_diff, result_is_temp} <= 17'($urandom);
      {temp_first, temp_second} <= 24'($urandom);
      result_valid <= 1'b1;
      @(posedge core_clk);
      result_valid <= 1'b0;
      host.got = 16'h0000;
      host.frame(40'h0, 5);
      f = p[7 - result_pair] & !u[7 - result_pair] & result_is_diff;
      if (result_is_temp) chk("temp", host.got, {4'h0, temp_first - temp_second - asc_pkg::TEMP_OFFSET});
      else chk("word", host.got, {4'h0, result_code ^ {f, 9'h000}, result_subbits});
    end
    $display("result test done");
    test_done();
  end
endmodule : adc_serial_config_registers_tb_top
